// [burst_sram_defs.vh]
// constants for the pipelined burst sram cycle decode
`ifndef BURST_SRAM_DEFS_VH
`define BURST_SRAM_DEFS_VH

// geometry of the wide part
`define ADDR_W 19
`define DEPTH 524288
`define LANES 4
`define LANE_W 8
`define WORD_W 36
`define DATA_W 32

// burst order select level as sampled
`define ORDER_LINEAR 1'b0
`define ORDER_INTERLEAVED 1'b1

// cycle types held after each clock rise
`define CYC_IDLE 2'h0
`define CYC_READ 2'h1
`define CYC_WRITE 2'h2

`endif

// [burst_order_counter.v]
// two-bit wrapping burst counter with interleaved or linear order
`include "burst_sram_defs.vh"

module burst_order_counter (
	// clock and reset
	input wire clk,
	input wire rst,
	// control
	input wire load,
	input wire [1:0] load_lsb,
	input wire step,
	input wire linear,
	// burst address low bits
	output wire [1:0] cur_lsb,
	output wire [1:0] next_lsb
);

	reg [1:0] base_r;
	reg [1:0] count_r;

	// =====================================
	// order table
	function [1:0] order_addr;
		input [1:0] base;
		input [1:0] cnt;
		input lin;
		begin
			if (lin) begin
				order_addr = base + cnt;
			end else begin
				order_addr = base ^ cnt;
			end
		end
	endfunction

	assign cur_lsb = order_addr(base_r, count_r, linear);
	assign next_lsb = order_addr(base_r, count_r + 2'h1, linear);

	// =====================================
	// counter state
	always @(posedge clk) begin
		if (rst) begin
			base_r <= 2'h0;
			count_r <= 2'h0;
		end else if (load) begin
			base_r <= load_lsb;
			count_r <= 2'h0;
		end else if (step) begin
			count_r <= count_r + 2'h1;
		end
	end

endmodule

// [sync_burst_sram_cycle_decode.v]
// cycle decode, byte lanes, burst addressing and data drive of the burst sram
`include "burst_sram_defs.vh"

module sync_burst_sram_cycle_decode (
	// clock and reset
	input wire clk,
	input wire rst,
	// address and burst control, synchronous
	input wire [`ADDR_W-1:0] address,
	input wire processor_address_strobe_n,
	input wire controller_address_strobe_n,
	input wire burst_advance_n,
	// chip selects, synchronous
	input wire primary_chip_select_n,
	input wire depth_select_high,
	input wire depth_select_low_n,
	// write controls, synchronous
	input wire global_write_n,
	input wire byte_write_gate_n,
	input wire [`LANES-1:0] byte_lane_write_select_n,
	// burst order strap
	input wire burst_order_select,
	// asynchronous output enable
	input wire output_drive_enable_n,
	// data and parity lines
	input wire [`DATA_W-1:0] dq_in,
	output reg [`DATA_W-1:0] dq_out,
	output wire dq_oe,
	input wire [`LANES-1:0] parity_lines_in,
	output reg [`LANES-1:0] parity_lines_out,
	output wire parity_lines_oe
);

	reg [`WORD_W-1:0] mem [0:`DEPTH-1];
	reg [1:0] cycle_r;
	reg active_r;
	reg [`ADDR_W-3:0] addr_hi_r;
	reg order_meta_r;
	reg order_r;
	reg [`LANES-1:0] lane_we;
	reg [`ADDR_W-1:0] eff_addr;
	reg [1:0] cycle_nxt;
	reg load;
	reg step;
	integer i;
	integer j;

	wire [1:0] cur_lsb;
	wire [1:0] next_lsb;

	// =====================================
	// write control decode
	function [`LANES-1:0] lane_mask;
		input gw_n;
		input bwe_n;
		input [`LANES-1:0] bw_n;
		begin
			if (!gw_n) begin
				lane_mask = {`LANES{1'b1}};
			end else if (!bwe_n) begin
				lane_mask = ~bw_n;
			end else begin
				lane_mask = {`LANES{1'b0}};
			end
		end
	endfunction

	// first bit of a lane inside a stored word, parity bit on top
	function integer lane_base;
		input integer lane;
		begin
			lane_base = lane * (`LANE_W + 1);
		end
	endfunction

	wire [`LANES-1:0] req_lanes = lane_mask(global_write_n, byte_write_gate_n, byte_lane_write_select_n);
	wire write_cond = |req_lanes;
	wire proc_start = ~processor_address_strobe_n & ~primary_chip_select_n;
	wire ctrl_start = ~controller_address_strobe_n;
	wire selected = ~primary_chip_select_n & depth_select_high & ~depth_select_low_n;

	// =====================================
	// burst order strap, two stages
	always @(posedge clk) begin
		if (rst) begin
			order_meta_r <= `ORDER_INTERLEAVED;
			order_r <= `ORDER_INTERLEAVED;
		end else begin
			order_meta_r <= burst_order_select;
			order_r <= order_meta_r;
		end
	end

	burst_order_counter counter_u (
		.clk(clk),
		.rst(rst),
		.load(load),
		.load_lsb(address[1:0]),
		.step(step),
		.linear(order_r == `ORDER_LINEAR),
		.cur_lsb(cur_lsb),
		.next_lsb(next_lsb)
	);

	// =====================================
	// cycle decode
	always @* begin
		cycle_nxt = `CYC_IDLE;
		lane_we = {`LANES{1'b0}};
		eff_addr = address;
		load = 1'b0;
		step = 1'b0;
		if (proc_start || ctrl_start) begin
			load = 1'b1;
			if (selected) begin
				if (proc_start) begin
					cycle_nxt = `CYC_READ;
				end else if (write_cond) begin
					cycle_nxt = `CYC_WRITE;
					lane_we = req_lanes;
				end else begin
					cycle_nxt = `CYC_READ;
				end
			end
		end else if (active_r) begin
			if (!burst_advance_n) begin
				step = 1'b1;
				eff_addr = {addr_hi_r, next_lsb};
			end else begin
				eff_addr = {addr_hi_r, cur_lsb};
			end
			if (write_cond) begin
				cycle_nxt = `CYC_WRITE;
				lane_we = req_lanes;
			end else begin
				cycle_nxt = `CYC_READ;
			end
		end
	end

	// =====================================
	// cycle state and array access
	always @(posedge clk) begin
		if (rst) begin
			cycle_r <= `CYC_IDLE;
			active_r <= 1'b0;
			addr_hi_r <= {(`ADDR_W-2){1'b0}};
			dq_out <= {`DATA_W{1'b0}};
			parity_lines_out <= {`LANES{1'b0}};
		end else begin
			cycle_r <= cycle_nxt;
			if (load) begin
				active_r <= selected;
				addr_hi_r <= address[`ADDR_W-1:2];
			end
			if (cycle_nxt == `CYC_READ) begin
				for (i = 0; i < `LANES; i = i + 1) begin
					dq_out[i*`LANE_W +: `LANE_W] <= mem[eff_addr][lane_base(i) +: `LANE_W];
					parity_lines_out[i] <= mem[eff_addr][lane_base(i) + `LANE_W];
				end
			end
		end
	end

	// memory words carry no reset
	always @(posedge clk) begin
		for (j = 0; j < `LANES; j = j + 1) begin
			if (!rst && lane_we[j]) begin
				mem[eff_addr][lane_base(j) +: (`LANE_W+1)] <=
					{parity_lines_in[j], dq_in[j*`LANE_W +: `LANE_W]};
			end
		end
	end

	// =====================================
	// drive enable from cycle type and live enable level
	assign dq_oe = (cycle_r == `CYC_READ) & ~output_drive_enable_n;
	assign parity_lines_oe = (cycle_r == `CYC_READ) & ~output_drive_enable_n;

endmodule

// [sram_checker_assertions.sv]
// pin-level assertions for the burst sram cycle decode
module sram_checker (
	// clock and reset
	input wire clk,
	input wire rst,
	// synchronous controls and the asynchronous output enable
	input wire processor_address_strobe_n,
	input wire controller_address_strobe_n,
	input wire primary_chip_select_n,
	input wire depth_select_high,
	input wire depth_select_low_n,
	input wire global_write_n,
	input wire byte_write_gate_n,
	input wire [3:0] byte_lane_write_select_n,
	input wire output_drive_enable_n,
	// data drive
	input wire [31:0] dq_out,
	input wire dq_oe,
	input wire parity_lines_oe
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	wire sel = !primary_chip_select_n & depth_select_high & !depth_select_low_n;
	wire ps = !processor_address_strobe_n & sel;
	wire cs = !controller_address_strobe_n & processor_address_strobe_n & sel;
	wire cont = controller_address_strobe_n & (processor_address_strobe_n | primary_chip_select_n);
	wire wr = !global_write_n | !byte_write_gate_n & ~&byte_lane_write_select_n;
	wire oe = !output_drive_enable_n;
	oe_live_a: assert property (!oe |-> !dq_oe) else $error("drive with enable off");
	all_bits_a: assert property (parity_lines_oe == dq_oe) else $error("lane enables split");
	wr_mask_a: assert property (cont & wr |=> !dq_oe) else $error("drive in write");
	wr_hold_a: assert property (cont & wr |=> $stable(dq_out)) else $error("output moved in write");
	strobe_rd_a: assert property (ps ##1 oe |-> dq_oe) else $error("strobe read not driven");
	ctl_rd_a: assert property (cs & !wr ##1 oe |-> dq_oe) else $error("read not driven");
	desel_a: assert property (!controller_address_strobe_n & !sel |=> !dq_oe) else $error("deselect drive");
	reset_a: assert property (disable iff (1'b0) rst |=> dq_out == 32'h0 && !dq_oe) else $error("reset");
	cover property (ps);
	cover property (cont & wr);
	cover property (cs & !wr);
endmodule

// [sram_master.sv]
// bus master model for the burst sram pins
module sram_master (
	// clock
	input wire clk,
	// controls and data
	output logic [8:0] ctl,
	output logic [18:0] a,
	output logic [31:0] d,
	output logic oe_n
);
	timeunit 1ns;
	timeprecision 1ns;
	logic oe_lvl = 1'b0;
	initial {ctl, a, d, oe_n} = {9'h1ff, 19'h0, 32'h0, 1'b1};
	// one cycle; released data shows inverted last value
	task op(input [8:0] c, input [18:0] ad, input [31:0] dd);
		logic w;
		@(negedge clk);
		w = c[8] & (!c[5] | !c[4] & ~&c[3:0]);
		ctl = c;
		a = ad;
		d = w ? dd : ~d;
		oe_n = oe_lvl | w;
	endtask
endmodule

// [sync_burst_sram_cycle_decode_test.sv]
// self-checking bench for the burst sram cycle decode
module sync_burst_sram_cycle_decode_test;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 0, rst = 1, sel_n = 0, ord = 1;
	wire [8:0] ctl;
	wire [18:0] a;
	wire [31:0] d, dq_out;
	wire [3:0] par_out;
	wire dq_oe, par_oe, oe_n;
	int fail_count = 0, checked = 0;
	initial forever #5 clk = ~clk;
	sram_master m (.clk(clk), .ctl(ctl), .a(a), .d(d), .oe_n(oe_n));
	sync_burst_sram_cycle_decode i_dut (
		.clk(clk),
		.rst(rst),
		.address(a),
		.processor_address_strobe_n(ctl[8]),
		.controller_address_strobe_n(ctl[7]),
		.burst_advance_n(ctl[6]),
		.primary_chip_select_n(sel_n),
		.depth_select_high(1'b1),
		.depth_select_low_n(1'b0),
		.global_write_n(ctl[5]),
		.byte_write_gate_n(ctl[4]),
		.byte_lane_write_select_n(ctl[3:0]),
		.burst_order_select(ord),
		.output_drive_enable_n(oe_n),
		.dq_in(dq_oe ? dq_out : d),
		.dq_out(dq_out),
		.dq_oe(dq_oe),
		.parity_lines_in(par_oe ? par_out : d[3:0]),
		.parity_lines_out(par_out),
		.parity_lines_oe(par_oe)
	);
	task chk(input string n, input [31:0] e, s);
		checked++;
		if (s !== e) begin
			fail_count++;
			$display("[FAIL] %s exp %h got %h", n, e, s);
		end
	endtask
	task rd(input [8:0] c, input [18:0] ad, input [31:0] e);
		m.op(c, ad, 32'h0);
		@(posedge clk);
		#1 chk("dq_out", e, dq_out);
	endtask
	// burst write at base 1, single reads, then burst read
	task t_order(input o, input [31:0] v, input [7:0] seq);
		ord = o;
		repeat (3) @(negedge clk);
		for (int i = 0; i < 4; i++) m.op(i ? 9'h19f : 9'h15f, 19'h5, v + i);
		for (int i = 0; i < 4; i++) rd(9'h0df, {17'h1, seq[2*i+:2]}, v + i);
		rd(9'h0df, 19'h5, v);
		for (int i = 1; i < 4; i++) rd(9'h1bf, 19'h0, v + i);
	endtask
	task t_lanes;
		m.op(9'h15f, 19'h8, 32'h0);
		m.op(9'h1e5, 19'h0, 32'hffffffff);
		rd(9'h0c0, 19'h8, 32'hff00ff00);
		chk("parity", 32'ha, par_out);
		rd(9'h170, 19'h8, 32'hff00ff00);
	endtask
	task t_drive;
		m.oe_lvl = 1;
		rd(9'h0df, 19'h8, 32'hff00ff00);
		chk("dq_oe", 0, dq_oe);
		@(negedge clk) m.oe_n = 0;
		#1 chk("dq_oe", 1, dq_oe);
		m.op(9'h15f, 19'h9, 32'h1);
		@(posedge clk);
		@(negedge clk) m.oe_n = 0;
		#1 chk("dq_oe", 0, dq_oe);
		sel_n = 1;
		m.oe_lvl = 0;
		m.op(9'h17f, 19'h8, 32'h0);
		@(posedge clk);
		#1 chk("dq_oe", 0, dq_oe);
	endtask
	task end_of_test;
		if (fail_count == 0 && checked > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		repeat (5) @(negedge clk);
		rst = 0;
		t_order(1, 32'hd0, 8'hb1);
		t_order(0, 32'he0, 8'h39);
		t_lanes;
		t_drive;
		end_of_test;
	end
endmodule
bind sync_burst_sram_cycle_decode sram_checker i_chk (.clk, .rst, .processor_address_strobe_n,
	.controller_address_strobe_n, .primary_chip_select_n, .depth_select_high, .depth_select_low_n,
	.global_write_n, .byte_write_gate_n, .byte_lane_write_select_n, .output_drive_enable_n,
	.dq_out, .dq_oe, .parity_lines_oe);
